// ---- verilog/mio_top.v ----
// Motion I/O conditioning: polarity, routing and packed status of system I/O.
// Assumes a sequencer on the same clock supplies function outputs, and that
// software reaches the settings over Avalon-MM with waitrequest.
//
// The address map and the Avalon-MM slave port were chosen for this implementation.
`include "mio_defs.vh"

module mio_top #(
  parameter ADDR_W = 6
) (
  // Clock and reset.
  input  wire                       ref_clk_in,
  input  wire                       rst_n_in,
  // Avalon-MM slave.
  input  wire [ADDR_W-1:0]          avs_address_in,
  input  wire                       avs_read_in,
  input  wire                       avs_write_in,
  input  wire [31:0]                avs_writedata_in,
  input  wire [3:0]                 avs_byteenable_in,
  output wire                       avs_waitrequest_out,
  output wire [31:0]                avs_readdata_out,
  // Contact pins.
  input  wire [`MIO_DED_IN_W-1:0]   ded_in_pin_in,
  input  wire [`MIO_GEN_IN_W-1:0]   gen_in_pin_in,
  // Function outputs from the sequencer, high when on.
  input  wire [`MIO_SYS_OUT_W-1:0]  func_out_in,
  // Load lines.
  output wire [1:0]                 ded_out_pin_out,
  output wire [`MIO_GEN_OUT_W-1:0]  gen_out_pin_out,
  // Conditioned functional inputs to the sequencer.
  output wire [`MIO_SYS_IN_W-1:0]   system_input_word_out,
  output wire                       pause_out,
  output wire                       pause_clear_out
);

  // Pending settings written by software.
  reg  [`MIO_SYS_IN_W-1:0]  in_pol_pend_reg;
  reg  [`MIO_SYS_OUT_W-1:0] out_pol_pend_reg;
  reg  [`MIO_GEN_IN_W-1:0]  gen_pol_pend_reg;
  reg  [`MIO_ROUTE_W-1:0]   pause_route_pend_reg;
  reg  [`MIO_ROUTE_W-1:0]   pclear_route_pend_reg;
  reg  [`MIO_ROUTE_W*`MIO_N_OUT_ROUTES-1:0] out_route_pend_reg;
  // Active settings used by the logic.
  reg  [`MIO_SYS_IN_W-1:0]  in_pol_reg;
  reg  [`MIO_SYS_OUT_W-1:0] out_pol_reg;
  reg  [`MIO_GEN_IN_W-1:0]  gen_pol_reg;
  reg  [`MIO_ROUTE_W-1:0]   pause_route_reg;
  reg  [`MIO_ROUTE_W-1:0]   pclear_route_reg;
  reg  [`MIO_ROUTE_W*`MIO_N_OUT_ROUTES-1:0] out_route_reg;
  // Manual output bits and output flops.
  reg  [`MIO_GEN_OUT_W-1:0] gen_out_reg;
  reg  [`MIO_GEN_OUT_W-1:0] gen_out_pin_reg;
  reg  [`MIO_GEN_OUT_W-1:0] gen_out_next;
  reg  [1:0]                ded_out_pin_reg;
  // Bus handshake.
  reg                       ack_reg;
  reg  [31:0]               rdata_reg;
  reg  [31:0]               rdata_next;
  // Conditioned inputs.
  wire [`MIO_DED_IN_W-1:0]  ded_state;
  wire [`MIO_GEN_IN_W-1:0]  gen_state;
  wire [`MIO_DED_IN_W-1:0]  ded_pol;
  reg                       pause_sel;
  reg                       pclear_sel;
  reg                       pause_reg;
  reg                       pclear_reg;
  wire [`MIO_SYS_IN_W-1:0]  sys_in_word;
  wire                      req;
  wire                      wr_take;
  integer                   i;
  integer                   j;
  integer                   r;

  // Dedicated pin polarities skip the two routed functions.
  assign ded_pol = {in_pol_reg[`MIO_SYS_IN_W-1:`MIO_SI_PCLEAR+1],
                    in_pol_reg[`MIO_SI_PAUSE-1:0]};

  mio_sync_pol #(
    .WIDTH     (`MIO_DED_IN_W)
  ) u_ded_sync (
    .ref_clk_in (ref_clk_in),
    .rst_n_in   (rst_n_in),
    .pin_in     (ded_in_pin_in),
    .pol_in     (ded_pol),
    .state_out  (ded_state)
  );

  mio_sync_pol #(
    .WIDTH     (`MIO_GEN_IN_W)
  ) u_gen_sync (
    .ref_clk_in (ref_clk_in),
    .rst_n_in   (rst_n_in),
    .pin_in     (gen_in_pin_in),
    .pol_in     (gen_pol_reg),
    .state_out  (gen_state)
  );

  // pause and pause-clear route select; zero leaves the function unconnected.
  // This loop has its own index so that no variable is driven from two processes.
  always @* begin
    pause_sel  = 1'b0;
    pclear_sel = 1'b0;
    for (j = 0; j < `MIO_GEN_IN_W; j = j + 1) begin
      if (pause_route_reg == j + 1) begin
        pause_sel = gen_state[j];
      end
      if (pclear_route_reg == j + 1) begin
        pclear_sel = gen_state[j];
      end
    end
  end

  // Routed functions also carry their own polarity, and stay off when unrouted.
  always @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      pause_reg  <= 1'b0;
      pclear_reg <= 1'b0;
    end else begin
      pause_reg  <= (pause_route_reg != `MIO_ROUTE_NONE) &
                    (pause_sel ^ in_pol_reg[`MIO_SI_PAUSE]);
      pclear_reg <= (pclear_route_reg != `MIO_ROUTE_NONE) &
                    (pclear_sel ^ in_pol_reg[`MIO_SI_PCLEAR]);
    end
  end

  assign sys_in_word = {ded_state[`MIO_DED_IN_W-1:`MIO_SI_PAUSE], pclear_reg, pause_reg,
                        ded_state[`MIO_SI_PAUSE-1:0]};

  // route each function output other than alarm and move onto the general output it names.
  always @* begin
    gen_out_next = gen_out_reg;
    for (r = 0; r < `MIO_N_OUT_ROUTES; r = r + 1) begin
      for (i = 0; i < `MIO_GEN_OUT_W; i = i + 1) begin
        if (out_route_reg[r*`MIO_ROUTE_W +: `MIO_ROUTE_W] == i + 1) begin
          gen_out_next[i] = gen_out_next[i] |
                            (func_out_in[(r < 2) ? r + 1 : r + 2] ^
                             out_pol_reg[(r < 2) ? r + 1 : r + 2]);
        end
      end
    end
  end

  // Output pins come from flops so no glitch from the routing reaches a load.
  always @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      gen_out_pin_reg <= `MIO_GEN_OUT_RESET;
      ded_out_pin_reg <= 2'h0;
    end else begin
      gen_out_pin_reg <= gen_out_next;
      ded_out_pin_reg <= {func_out_in[`MIO_SO_MOVE] ^ out_pol_reg[`MIO_SO_MOVE],
                          func_out_in[`MIO_SO_ALARM] ^ out_pol_reg[`MIO_SO_ALARM]};
    end
  end

  // One wait cycle per access; the request is taken while ack is high.
  assign req                 = avs_read_in | avs_write_in;
  assign avs_waitrequest_out = req & ~ack_reg;
  assign wr_take             = avs_write_in & ack_reg;

  // Settings registers; polarities and routes only act after an apply.
  always @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      ack_reg               <= 1'b0;
      in_pol_pend_reg       <= {`MIO_SYS_IN_W{`MIO_POL_RESET}};
      out_pol_pend_reg      <= {`MIO_SYS_OUT_W{`MIO_POL_RESET}};
      gen_pol_pend_reg      <= {`MIO_GEN_IN_W{`MIO_POL_RESET}};
      pause_route_pend_reg  <= `MIO_ROUTE_NONE;
      pclear_route_pend_reg <= `MIO_ROUTE_NONE;
      out_route_pend_reg    <= {`MIO_N_OUT_ROUTES{`MIO_ROUTE_NONE}};
      in_pol_reg            <= {`MIO_SYS_IN_W{`MIO_POL_RESET}};
      out_pol_reg           <= {`MIO_SYS_OUT_W{`MIO_POL_RESET}};
      gen_pol_reg           <= {`MIO_GEN_IN_W{`MIO_POL_RESET}};
      pause_route_reg       <= `MIO_ROUTE_NONE;
      pclear_route_reg      <= `MIO_ROUTE_NONE;
      out_route_reg         <= {`MIO_N_OUT_ROUTES{`MIO_ROUTE_NONE}};
      gen_out_reg           <= `MIO_GEN_OUT_RESET;
    end else begin
      ack_reg <= req & ~ack_reg;
      if (wr_take && avs_byteenable_in == 4'hF) begin
        case (avs_address_in)
          `MIO_ADDR_SYS_IN_POL: begin
            in_pol_pend_reg <= avs_writedata_in[`MIO_SYS_IN_W-1:0];
          end
          `MIO_ADDR_SYS_OUT_POL: begin
            out_pol_pend_reg <= avs_writedata_in[`MIO_SYS_OUT_W-1:0];
          end
          `MIO_ADDR_GEN_IN_POL: begin
            gen_pol_pend_reg <= avs_writedata_in[`MIO_GEN_IN_W-1:0];
          end
          `MIO_ADDR_IN_ROUTE: begin
            pause_route_pend_reg  <= avs_writedata_in[`MIO_PAUSE_ROUTE_LSB +: `MIO_ROUTE_W];
            pclear_route_pend_reg <= avs_writedata_in[`MIO_PCLEAR_ROUTE_LSB +: `MIO_ROUTE_W];
          end
          `MIO_ADDR_OUT_ROUTE: begin
            out_route_pend_reg <= avs_writedata_in[`MIO_ROUTE_W*`MIO_N_OUT_ROUTES-1:0];
          end
          // settings take effect at a write of the apply bit.
          `MIO_ADDR_APPLY: begin
            if (avs_writedata_in[`MIO_APPLY_BIT]) begin
              in_pol_reg       <= in_pol_pend_reg;
              out_pol_reg      <= out_pol_pend_reg;
              gen_pol_reg      <= gen_pol_pend_reg;
              // Out-of-range input routes act as unassigned.
              pause_route_reg  <= (pause_route_pend_reg > 3'h6) ?
                                  `MIO_ROUTE_NONE : pause_route_pend_reg;
              pclear_route_reg <= (pclear_route_pend_reg > 3'h6) ?
                                  `MIO_ROUTE_NONE : pclear_route_pend_reg;
              out_route_reg    <= out_route_pend_reg;
            end
          end
          `MIO_ADDR_GEN_OUT: begin
            gen_out_reg <= avs_writedata_in[`MIO_GEN_OUT_W-1:0];
          end
          default: begin
            gen_out_reg <= gen_out_reg;
          end
        endcase
      end
    end
  end

  // Read mux, captured in the wait cycle so data stands at the taking edge.
  always @* begin
    rdata_next = 32'h0000_0000;
    case (avs_address_in)
      `MIO_ADDR_SYS_IN_POL:   rdata_next[`MIO_SYS_IN_W-1:0]  = in_pol_pend_reg;
      `MIO_ADDR_SYS_OUT_POL:  rdata_next[`MIO_SYS_OUT_W-1:0] = out_pol_pend_reg;
      `MIO_ADDR_GEN_IN_POL:   rdata_next[`MIO_GEN_IN_W-1:0]  = gen_pol_pend_reg;
      `MIO_ADDR_IN_ROUTE: begin
        rdata_next[`MIO_PAUSE_ROUTE_LSB +: `MIO_ROUTE_W]  = pause_route_pend_reg;
        rdata_next[`MIO_PCLEAR_ROUTE_LSB +: `MIO_ROUTE_W] = pclear_route_pend_reg;
      end
      `MIO_ADDR_OUT_ROUTE:
        rdata_next[`MIO_ROUTE_W*`MIO_N_OUT_ROUTES-1:0] = out_route_pend_reg;
      `MIO_ADDR_GEN_OUT:      rdata_next[`MIO_GEN_OUT_W-1:0] = gen_out_reg;
      `MIO_ADDR_GEN_IN_STAT:  rdata_next[`MIO_GEN_IN_W-1:0]  = gen_state;
      `MIO_ADDR_SYS_IN_STAT:  rdata_next[`MIO_SYS_IN_W-1:0]  = sys_in_word;
      `MIO_ADDR_SYS_OUT_STAT: rdata_next[`MIO_SYS_OUT_W-1:0] = func_out_in;
      `MIO_ADDR_GEN_OUT_STAT: rdata_next[`MIO_GEN_OUT_W-1:0] = gen_out_pin_reg;
      default:                rdata_next = 32'h0000_0000;
    endcase
  end

  always @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      rdata_reg <= 32'h0000_0000;
    end else if (avs_read_in && !ack_reg) begin
      rdata_reg <= rdata_next;
    end
  end

  assign avs_readdata_out      = rdata_reg;
  assign gen_out_pin_out       = gen_out_pin_reg;
  assign ded_out_pin_out       = ded_out_pin_reg;
  assign system_input_word_out = sys_in_word;
  assign pause_out             = pause_reg;
  assign pause_clear_out       = pclear_reg;

endmodule

// ---- verilog/mio_defs.vh ----
// Constants of the motion I/O polarity and routing block.
// Assumes a 32-bit Avalon-MM slave with byte addresses and one word per register.
`ifndef MIO_DEFS_VH
`define MIO_DEFS_VH

// Register byte offsets.
`define MIO_ADDR_SYS_IN_POL   6'h00
`define MIO_ADDR_SYS_OUT_POL  6'h04
`define MIO_ADDR_GEN_IN_POL   6'h08
`define MIO_ADDR_IN_ROUTE     6'h0C
`define MIO_ADDR_OUT_ROUTE    6'h10
`define MIO_ADDR_APPLY        6'h14
`define MIO_ADDR_GEN_OUT      6'h18
`define MIO_ADDR_GEN_IN_STAT  6'h1C
`define MIO_ADDR_SYS_IN_STAT  6'h20
`define MIO_ADDR_SYS_OUT_STAT 6'h24
`define MIO_ADDR_GEN_OUT_STAT 6'h28

// Field widths and positions.
`define MIO_SYS_IN_W     13
`define MIO_SYS_OUT_W    11
`define MIO_GEN_IN_W     6
`define MIO_GEN_OUT_W    4
`define MIO_DED_IN_W     11
`define MIO_ROUTE_W      3
`define MIO_N_OUT_ROUTES 9
`define MIO_PAUSE_ROUTE_LSB   0
`define MIO_PCLEAR_ROUTE_LSB  4
`define MIO_APPLY_BIT    0

// System input word bit positions.
`define MIO_SI_PAUSE     7
`define MIO_SI_PCLEAR    8
// System output word bit positions of the two dedicated outputs.
`define MIO_SO_ALARM     0
`define MIO_SO_MOVE      3

// Reset values.
`define MIO_POL_RESET    1'b0
`define MIO_ROUTE_NONE   3'h0
`define MIO_GEN_OUT_RESET 4'h0

`endif

// ---- verilog/mio_sync_pol.v ----
// Two-stage synchroniser for a group of contact pins, followed by polarity.
// Assumes pins are high while the contact is closed and come from outside the clock.
module mio_sync_pol #(
  parameter WIDTH = 6
) (
  // Clock and reset.
  input  wire             ref_clk_in,
  input  wire             rst_n_in,
  // Raw pins and active polarity.
  input  wire [WIDTH-1:0] pin_in,
  input  wire [WIDTH-1:0] pol_in,
  // Conditioned state, 1 when the signal is on.
  output wire [WIDTH-1:0] state_out
);

  reg [WIDTH-1:0] meta_reg;
  reg [WIDTH-1:0] sync_reg;
  reg [WIDTH-1:0] state_reg;

  // The first stage is read only by the second one.
  always @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      meta_reg  <= {WIDTH{1'b0}};
      sync_reg  <= {WIDTH{1'b0}};
      state_reg <= {WIDTH{1'b0}};
    end else begin
      meta_reg  <= pin_in;
      sync_reg  <= meta_reg;
      // A normally closed contact is on while the pin is open.
      state_reg <= sync_reg ^ pol_in;
    end
  end

  assign state_out = state_reg;

endmodule

// ---- dv/mio_contacts.sv ----
// Behavioural model of the external switches and sensors on the contact pins.
// Assumes the bench chooses which contacts are closed; a closed contact reads high.
module mio_contacts (
  // Contact states chosen by the bench.
  input  wire logic [10:0] ded_closed_in,
  input  wire logic [5:0]  gen_closed_in,
  // Pin levels seen by the block.
  output wire logic [10:0] ded_pin_out,
  output wire logic [5:0]  gen_pin_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // The switches are driven both ways, so an open contact reads low.
  assign ded_pin_out = ded_closed_in;
  assign gen_pin_out = gen_closed_in;
endmodule

// ---- dv/mio_top_asserts.sv ----
// Checker for the motion I/O block, bound to its top module.
// Assumes the polarity settings change only through full-word bus writes.
module mio_top_asserts #(
  parameter ADDR_W = 6
) (
  input wire logic              ref_clk_in,
  input wire logic              rst_n_in,
  input wire logic [ADDR_W-1:0] avs_address_in,
  input wire logic              avs_read_in,
  input wire logic              avs_write_in,
  input wire logic [31:0]       avs_writedata_in,
  input wire logic [3:0]        avs_byteenable_in,
  input wire logic              avs_waitrequest_out,
  input wire logic [31:0]       avs_readdata_out,
  input wire logic [10:0]       ded_in_pin_in,
  input wire logic [5:0]        gen_in_pin_in,
  input wire logic [10:0]       func_out_in,
  input wire logic [1:0]        ded_out_pin_out,
  input wire logic [3:0]        gen_out_pin_out,
  input wire logic [12:0]       system_input_word_out,
  input wire logic              pause_out,
  input wire logic              pause_clear_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);
  logic [12:0] si_pend_reg, si_act_reg;
  logic [10:0] so_pend_reg, so_act_reg;
  wire req = avs_read_in | avs_write_in;
  wire take_wr = avs_write_in & ~avs_waitrequest_out & (avs_byteenable_in == 4'hF);
  // Shadow of the system input and output polarity settings, so that pin levels can be predicted.
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      si_pend_reg <= 13'h0000;
      si_act_reg <= 13'h0000;
      so_pend_reg <= 11'h000;
      so_act_reg <= 11'h000;
    end else if (take_wr) begin
      if (avs_address_in == 6'h00) si_pend_reg <= avs_writedata_in[12:0];
      if (avs_address_in == 6'h04) so_pend_reg <= avs_writedata_in[10:0];
      if (avs_address_in == 6'h14 && avs_writedata_in[0]) begin
        si_act_reg <= si_pend_reg;
        so_act_reg <= so_pend_reg;
      end
    end
  end
  a_wait_first: assert property (req && !$past(req) |-> avs_waitrequest_out)
    else $error("first request cycle not stalled");
  a_wait_once: assert property (req && avs_waitrequest_out |=> !req || !avs_waitrequest_out)
    else $error("more than one wait cycle");
  a_wait_idle: assert property (!req |-> !avs_waitrequest_out)
    else $error("wait raised without request");
  a_read_zero: assert property (avs_read_in && !avs_waitrequest_out &&
    (avs_address_in == 6'h14 || avs_address_in > 6'h28) |-> avs_readdata_out == 32'h0)
    else $error("apply or unmapped read not zero");
  a_reset_clear: assert property (!$past(rst_n_in) |-> gen_out_pin_out == 4'h0 &&
    system_input_word_out == 13'h0000 && ded_out_pin_out == 2'h0)
    else $error("outputs not cleared by reset");
  a_alarm_level: assert property ($past(rst_n_in) |-> ded_out_pin_out[0] ==
    ($past(func_out_in[0]) ^ $past(so_act_reg[0]))) else $error("alarm pin level wrong");
  a_move_level: assert property ($past(rst_n_in) |-> ded_out_pin_out[1] ==
    ($past(func_out_in[3]) ^ $past(so_act_reg[3]))) else $error("move pin level wrong");
  property in_word_p;
    $past(rst_n_in) && $past(rst_n_in, 2) && $past(rst_n_in, 3) |->
      system_input_word_out[6:0] == ($past(ded_in_pin_in[6:0], 3) ^ $past(si_act_reg[6:0])) &&
      system_input_word_out[12:9] == ($past(ded_in_pin_in[10:7], 3) ^ $past(si_act_reg[12:9]));
  endproperty
  a_in_word: assert property (in_word_p)
    else $error("system input word wrong");
  a_pause_bits: assert property (pause_out == system_input_word_out[7] &&
    pause_clear_out == system_input_word_out[8]) else $error("pause bits differ from word");
  c_apply: cover property (take_wr && avs_address_in == 6'h14);
  c_read: cover property (avs_read_in && !avs_waitrequest_out);
  c_pause: cover property ($rose(pause_out));
endmodule
bind mio_top mio_top_asserts #(.ADDR_W(ADDR_W)) i_mio_top_asserts (.*);

// ---- dv/mio_top_tb.sv ----
// Self-checking bench for the motion I/O block.
// Assumes the contact model on the pins and a sequencer driven from here.
module mio_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk_in, rst_n_in, rd, wr;
  logic [5:0] addr, gen_cl;
  logic [31:0] wd, rv;
  logic [3:0] be, gen_out;
  logic [10:0] ded_cl, func, ded_pin;
  logic [5:0] gen_pin;
  logic [1:0] ded_out;
  logic [12:0] siw;
  logic wait_w, p_out, pc_out;
  logic [31:0] rdata;
  int err_total, n_tests, cyc;
  int fb[9] = '{1, 2, 4, 5, 6, 7, 8, 9, 10};
  mio_contacts i_mio_contacts (.ded_closed_in(ded_cl), .gen_closed_in(gen_cl),
    .ded_pin_out(ded_pin), .gen_pin_out(gen_pin));
  mio_top i_mio_top (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .avs_address_in(addr),
    .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd), .avs_byteenable_in(be),
    .avs_waitrequest_out(wait_w), .avs_readdata_out(rdata), .ded_in_pin_in(ded_pin),
    .gen_in_pin_in(gen_pin), .func_out_in(func), .ded_out_pin_out(ded_out),
    .gen_out_pin_out(gen_out), .system_input_word_out(siw), .pause_out(p_out),
    .pause_clear_out(pc_out));
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // The request is held until waitrequest is sampled low at a rising edge.
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d,
                     input logic [3:0] b);
    @(posedge ref_clk_in);
    addr <= a;
    wd <= d;
    be <= b;
    wr <= w;
    rd <= !w;
    do @(posedge ref_clk_in); while (wait_w !== 1'b0);
    rv = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic set(input logic [5:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 4'hF);
    bus(1'b1, 6'h14, 32'h1, 4'hF);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_in);
  endtask
  task automatic t_defaults;
    for (int a = 0; a <= 'h3C; a += 4) begin
      bus(1'b0, a[5:0], 32'h0, 4'hF);
      chk("reset value", rv, 32'h0);
    end
  endtask
  task automatic t_in_pol;
    bus(1'b1, 6'h00, 32'h1FFF, 4'hF);
    tick(4);
    chk("pending polarity", siw, 13'h0000);
    set(6'h3C, 32'h0);
    tick(3);
    bus(1'b0, 6'h20, 32'h0, 4'hF);
    chk("inverted inputs", rv, 32'h1E7F);
    ded_cl <= 11'h7FF;
    tick(4);
    chk("closed inverted", siw, 13'h0000);
    set(6'h00, 32'h0);
    tick(3);
    chk("closed normal", siw, 13'h1E7F);
    ded_cl <= 11'h000;
  endtask
  task automatic t_gen_in;
    for (int k = 0; k < 6; k++) begin
      gen_cl <= 6'h01 << k;
      tick(4);
      bus(1'b0, 6'h1C, 32'h0, 4'hF);
      chk("general input", rv, 32'h1 << k);
    end
    set(6'h08, 32'h3F);
    tick(3);
    bus(1'b0, 6'h1C, 32'h0, 4'hF);
    chk("inverted general", rv, 32'h1F);
    set(6'h08, 32'h0);
    gen_cl <= 6'h00;
  endtask
  task automatic t_in_route;
    for (int r = 1; r <= 6; r++) begin
      set(6'h0C, r | ((7 - r) << 4));
      gen_cl <= 6'h01 << (r - 1);
      tick(5);
      chk("pause routed", {p_out, pc_out}, 2'b10);
      gen_cl <= 6'h01 << (6 - r);
      tick(5);
      chk("clear routed", {p_out, pc_out}, 2'b01);
    end
    set(6'h0C, 32'h0);
    gen_cl <= 6'h3F;
    tick(5);
    chk("unassigned", {p_out, pc_out}, 2'b00);
    set(6'h0C, 32'h77);
    tick(5);
    chk("route seven", {p_out, pc_out}, 2'b00);
    set(6'h0C, 32'h21);
    set(6'h00, 32'h180);
    gen_cl <= 6'h01;
    tick(5);
    chk("routed polarity", {p_out, pc_out}, 2'b01);
    set(6'h00, 32'h0);
    set(6'h0C, 32'h0);
    gen_cl <= 6'h00;
  endtask
  task automatic t_out_route;
    for (int r = 0; r < 9; r++) begin
      set(6'h10, ((r % 4) + 1) << (3 * r));
      func <= 11'h001 << fb[r];
      tick(2);
      chk("routed output", gen_out, 4'h1 << (r % 4));
      bus(1'b0, 6'h24, 32'h0, 4'hF);
      chk("output word", rv, 32'h1 << fb[r]);
      func <= 11'h000;
      tick(2);
      chk("routed off", gen_out, 4'h0);
    end
    set(6'h10, 32'h1);
    set(6'h04, 32'h2);
    tick(2);
    chk("inverted route", gen_out, 4'h1);
    set(6'h10, 32'h5);
    tick(2);
    chk("route five", gen_out, 4'h0);
    set(6'h04, 32'h0);
    set(6'h10, 32'h0);
  endtask
  task automatic t_manual;
    for (int k = 0; k < 4; k++) begin
      bus(1'b1, 6'h18, 32'h1 << k, 4'hF);
      bus(1'b0, 6'h28, 32'h0, 4'hF);
      chk("manual output", rv, 32'h1 << k);
    end
    bus(1'b1, 6'h18, 32'hF, 4'h3);
    tick(2);
    chk("partial write", gen_out, 4'h8);
    bus(1'b1, 6'h18, 32'h0, 4'hF);
  endtask
  task automatic t_ded_out;
    func <= 11'h001;
    bus(1'b1, 6'h04, 32'h9, 4'hF);
    tick(2);
    chk("pending out pol", ded_out, 2'b01);
    set(6'h04, 32'h9);
    tick(2);
    chk("inverted out", ded_out, 2'b10);
    set(6'h04, 32'h0);
    func <= 11'h000;
  endtask
  // A reset in mid-run must bring back the manual outputs and the pending general input polarity.
  task automatic t_reset;
    bus(1'b1, 6'h18, 32'hF, 4'hF);
    bus(1'b1, 6'h08, 32'h3F, 4'hF);
    rst_n_in <= 1'b0;
    tick(2);
    rst_n_in <= 1'b1;
    tick(3);
    chk("reset outputs", gen_out, 4'h0);
    bus(1'b0, 6'h08, 32'h0, 4'hF);
    chk("reset polarity", rv, 32'h0);
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    ref_clk_in = 1'b0;
    forever #5 ref_clk_in = ~ref_clk_in;
  end
  // A hung handshake is cut short well beyond the expected run length.
  always @(posedge ref_clk_in) begin
    cyc++;
    if (cyc == 8000) begin
      err_total++;
      final_report();
    end
  end
  initial begin
    {rd, wr, addr, wd, be, ded_cl, gen_cl, func} = '0;
    rst_n_in = 1'b0;
    tick(4);
    rst_n_in <= 1'b1;
    tick(3);
    t_defaults();
    t_in_pol();
    t_gen_in();
    t_in_route();
    t_out_route();
    t_manual();
    t_ded_out();
    t_reset();
    final_report();
  end
endmodule
